// file: src/adcsq_pkg.sv
package adcsq_pkg;
   localparam int CLK_MHZ       = 50;
   localparam int DS_W          = 20;
   localparam int RES_W         = 5;
   localparam int DS_PRIME      = 3;
   localparam int DS_TAPS       = 4;
   localparam int DS_SETTLE     = 4;
   localparam int DS_TURBO_RES  = 17;
   localparam int DS_PERIOD_DEF = 64;
   localparam int SAR_N         = 2;
   localparam int SAR_W         = 12;
   localparam int SAR_TICKS     = 16;
   localparam int SAR_MAX_MHZ   = 16;
   localparam int SAR_DIV       = (CLK_MHZ + SAR_MAX_MHZ - 1) / SAR_MAX_MHZ;
   localparam int SAR_WAIT_US   = 10;
   localparam int SAR_WAIT_CYC  = SAR_WAIT_US * CLK_MHZ;
   localparam int WAIT_W        = $clog2(SAR_WAIT_CYC + 1);
   localparam int RES_DEF       = 16;

   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STAT   = 8'h04;
   localparam logic [7:0] ADR_DS_RES = 8'h08;
   localparam logic [7:0] ADR_SAR    = 8'h0C;

   localparam int CB_DS_START = 0;
   localparam int CB_DS_STOP  = 1;
   localparam int CB_MODE     = 2;
   localparam int CB_MUX      = 4;
   localparam int CB_SAR_GO   = 5;
   localparam int CB_WAKE     = 7;
   localparam int CB_RES      = 8;
   localparam int CB_SINGLE   = 13;

   localparam int SB_DS_EOC   = 0;
   localparam int SB_DS_VALID = 1;
   localparam int SB_DS_BUSY  = 2;
   localparam int SB_SAR_EOC  = 3;
   localparam int SB_SAR_RDY  = 5;

   typedef enum logic [1:0] {
      ADCSQ_SINGLE,
      ADCSQ_MULTI,
      ADCSQ_CONT,
      ADCSQ_TURBO
   } adcsq_mode_t;
endpackage

// file: src/adcsq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcsq_if;
   import adcsq_pkg::*;
   logic                            ds_start;
   logic                            ds_stop;
   logic                            ds_hw_start;
   logic                            ds_mux;
   logic                            ds_rd;
   adcsq_mode_t                     ds_mode;
   logic [RES_W-1:0]                ds_res;
   logic                            ds_eoc;
   logic                            ds_valid;
   logic                            ds_busy;
   logic [DS_W-1:0]                 ds_result;
   logic                            sar_tick;
   logic                            sar_wake;
   logic [SAR_N-1:0]                sar_start;
   logic [SAR_N-1:0]                sar_sof;
   logic [SAR_N-1:0]                sar_single;
   logic [SAR_N-1:0]                sar_rd;
   logic [SAR_N-1:0]                sar_eoc;
   logic [SAR_N-1:0]                sar_ready;
   logic [SAR_N-1:0][SAR_W-1:0]     sar_result;

   modport dev (
      input  ds_start, ds_stop, ds_hw_start, ds_mux, ds_rd, ds_mode, ds_res,
      input  sar_tick, sar_wake, sar_start, sar_sof, sar_single, sar_rd,
      output ds_eoc, ds_valid, ds_busy, ds_result, sar_eoc, sar_ready, sar_result
   );
   modport ctl (
      output ds_start, ds_stop, ds_hw_start, ds_mux, ds_rd, ds_mode, ds_res,
      output sar_tick, sar_wake, sar_start, sar_sof, sar_single, sar_rd,
      input  ds_eoc, ds_valid, ds_busy, ds_result, sar_eoc, sar_ready, sar_result
   );
endinterface
`default_nettype wire

// file: src/adcsq_sar.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar (
   input  wire logic                       mclk_i,
   input  wire logic                       nrst_i,
   input  wire logic                       ce_i,
   input  wire logic                       tick_i,
   input  wire logic                       go_i,
   input  wire logic                       cmp_i,
   output logic [adcsq_pkg::SAR_W-1:0]     dac_o,
   output logic [adcsq_pkg::SAR_W-1:0]     result_o,
   output logic                            done_o,
   output logic                            busy_o
);
   import adcsq_pkg::*;
   typedef enum logic [1:0] {S_IDLE, S_SAMP, S_CONV, S_TAIL} adcsq_sar_st_t;

   adcsq_sar_st_t    state;
   logic [3:0]       tick_cnt;
   logic [SAR_W-1:0] trial;
   logic [SAR_W-1:0] kept;

   // Drop the trial bit when the input sits below the DAC
   assign kept = cmp_i ? dac_o : (dac_o ^ trial);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state    <= S_IDLE;
         tick_cnt <= '0;
         trial    <= '0;
         dac_o    <= '0;
         result_o <= '0;
         done_o   <= 1'b0;
         busy_o   <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (state)
            S_IDLE: begin
               if (go_i) begin
                  state    <= S_SAMP;
                  tick_cnt <= '0;
                  busy_o   <= 1'b1;
               end
            end
            S_SAMP: begin
               if (tick_i) begin
                  state    <= S_CONV;
                  tick_cnt <= tick_cnt + 4'h1;
                  trial    <= {1'b1, {(SAR_W-1){1'b0}}};
                  dac_o    <= {1'b1, {(SAR_W-1){1'b0}}};
               end
            end
            S_CONV: begin
               if (tick_i) begin
                  tick_cnt <= tick_cnt + 4'h1;
                  if (trial[0]) begin // R10
                     result_o <= kept;
                     state    <= S_TAIL;
                  end else begin
                     trial <= trial >> 1; // R10
                     dac_o <= kept | (trial >> 1); // R10
                  end
               end
            end
            S_TAIL: begin
               if (tick_i) begin
                  if (tick_cnt == 4'(SAR_TICKS - 1)) begin
                     state  <= S_IDLE;
                     done_o <= 1'b1;
                     busy_o <= 1'b0;
                  end else begin
                     tick_cnt <= tick_cnt + 4'h1;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: src/adcsq_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Continuous: three priming periods, then each period
// R02: Host avoids mux switching in continuous mode
// R03: Multi-sample: reset and re-prime decimator per sample
// R04: Multi-sample: next sample starts by itself
// R05: Results readable by polling, interrupt or DMA
// R06: Turbo at 8..16 bits equals multi-sample
// R07: Turbo at 17..20 bits resets only once
// R08: Hardware start input begins a conversion
// R09: SAR converters give 12-bit results
// R10: SAR bits decided MSB to LSB by search
// R11: SAR clock sixteen per sample, max 16 MHz
// R12: SAR starts on start bit or hardware start
// R13: SAR hardware start optional, from clock or logic
// R14: SAR waits 10 us after power-up or wake
// R15: SAR done held until result read
// R16: SAR done usable as interrupt or DMA request
// R17: Single-conversion bit picks single_conversion_select or continuous
// R18: Continuous SAR samples movable by DMA
// R19: Delta-sigma done held until result read
// R20: Delta-sigma started by start bit or input
// R21: Data invalid until fourth sample after mux switch
// R22: Mode field selects delta-sigma operating mode
module adcsq_dev #(
   parameter int DS_PERIOD = adcsq_pkg::DS_PERIOD_DEF
) (
   input  wire logic                                        mclk_i,
   input  wire logic                                        nrst_i,
   input  wire logic                                        ce_i,
   adcsq_if.dev                                             lnk,
   input  wire logic [adcsq_pkg::DS_W-1:0]                  ds_mod_i,
   input  wire logic [adcsq_pkg::SAR_N-1:0]                 sar_cmp_i,
   output logic [adcsq_pkg::SAR_N-1:0][adcsq_pkg::SAR_W-1:0] sar_dac_o
);
   import adcsq_pkg::*;
   typedef enum logic [1:0] {DS_IDLE, DS_FILL, DS_RUN} adcsq_ds_st_t;

   adcsq_ds_st_t      ds_state;
   logic [15:0]       per_cnt;
   logic [1:0]        prime_cnt;
   logic [2:0]        settle_cnt;
   logic [DS_W-1:0]   taps [DS_TAPS-1];
   logic [DS_W+1:0]   dec_sum;
   logic              ds_go;
   logic              per_tick;
   logic              turbo_hi;
   logic              re_prime;
   logic              res_evt;
   logic              dec_clr;

   assign ds_go    = lnk.ds_start | lnk.ds_hw_start; // R08 R20
   assign per_tick = (ds_state != DS_IDLE) && (per_cnt == 16'(DS_PERIOD - 1));
   assign turbo_hi = (lnk.ds_mode == ADCSQ_TURBO) && (lnk.ds_res >= RES_W'(DS_TURBO_RES)); // R07
   // R06
   assign re_prime = (lnk.ds_mode == ADCSQ_MULTI) || ((lnk.ds_mode == ADCSQ_TURBO) && !turbo_hi);
   assign res_evt  = (ds_state == DS_RUN) && per_tick && !lnk.ds_stop;
   assign dec_clr  = ((ds_state == DS_IDLE) && ds_go) || (res_evt && re_prime); // R03

   // Decimator output spans the new sample and the last three
   always_comb begin
      dec_sum = {2'b00, ds_mod_i};
      for (int i = 0; i < DS_TAPS - 1; i++) begin
         dec_sum = dec_sum + {2'b00, taps[i]};
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         per_cnt <= '0;
      end else if (ce_i) begin
         if (ds_state == DS_IDLE || per_tick) begin
            per_cnt <= '0;
         end else begin
            per_cnt <= per_cnt + 16'h0001;
         end
      end
   end

   // Mode sequencing
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ds_state  <= DS_IDLE;
         prime_cnt <= '0;
      end else if (ce_i) begin
         if (lnk.ds_stop) begin
            ds_state <= DS_IDLE;
         end else begin
            case (ds_state)
               DS_IDLE: begin
                  if (ds_go) begin // R20
                     ds_state  <= DS_FILL;
                     prime_cnt <= '0;
                  end
               end
               DS_FILL: begin
                  if (per_tick) begin
                     if (prime_cnt == 2'(DS_PRIME - 1)) begin // R01
                        ds_state <= DS_RUN;
                     end else begin
                        prime_cnt <= prime_cnt + 2'h1;
                     end
                  end
               end
               DS_RUN: begin
                  if (per_tick) begin
                     case (lnk.ds_mode) // R22
                        ADCSQ_SINGLE: ds_state <= DS_IDLE;
                        ADCSQ_CONT: ds_state <= DS_RUN; // R01
                        default: begin
                           if (re_prime) begin // R03 R04 R06
                              ds_state  <= DS_FILL;
                              prime_cnt <= '0;
                           end else begin
                              ds_state <= DS_RUN; // R07
                           end
                        end
                     endcase
                  end
               end
               default: ds_state <= DS_IDLE;
            endcase
         end
      end
   end

   // Decimator history, one flop stage per past sample, three in all
   for (genvar t = 0; t < DS_TAPS - 1; t++) begin : g_tap
      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            taps[t] <= '0;
         end else if (ce_i) begin
            if (dec_clr) begin
               taps[t] <= '0; // R03
            end else if (per_tick) begin
               taps[t] <= (t == 0) ? ds_mod_i : taps[(t == 0) ? 0 : t - 1];
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lnk.ds_eoc    <= 1'b0;
         lnk.ds_result <= '0;
         lnk.ds_busy   <= 1'b0;
      end else if (ce_i) begin
         lnk.ds_busy <= (ds_state != DS_IDLE);
         if (res_evt) begin
            lnk.ds_eoc    <= 1'b1; // R19 R05
            lnk.ds_result <= dec_sum[DS_W+1:2];
         end else if (lnk.ds_rd) begin
            lnk.ds_eoc <= 1'b0; // R19
         end
      end
   end

   // Settling after an input switch
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         settle_cnt   <= '0;
         lnk.ds_valid <= 1'b0;
      end else if (ce_i) begin
         if (lnk.ds_mux) begin
            settle_cnt   <= '0; // R21
            lnk.ds_valid <= 1'b0;
         end else begin
            if (per_tick && settle_cnt < 3'(DS_SETTLE)) begin
               settle_cnt <= settle_cnt + 3'h1; // R21
            end
            lnk.ds_valid <= (settle_cnt >= 3'(DS_SETTLE)); // R21
         end
      end
   end

   // Successive-approximation channels
   for (genvar g = 0; g < SAR_N; g++) begin : g_sar
      logic [WAIT_W-1:0] wait_cnt;
      logic              run;
      logic              go;
      logic              done;
      logic              busy;
      logic              eoc;
      logic              rdy;
      logic [SAR_W-1:0]  res;
      logic [SAR_W-1:0]  eng_res;

      // R12 R17 R14
      assign go = (wait_cnt == '0) && !lnk.sar_wake && !busy &&
                  (lnk.sar_start[g] || lnk.sar_sof[g] || (run && !lnk.sar_single[g]));

      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            wait_cnt <= WAIT_W'(SAR_WAIT_CYC); // R14
            rdy      <= 1'b0;
         end else if (ce_i) begin
            if (lnk.sar_wake) begin
               wait_cnt <= WAIT_W'(SAR_WAIT_CYC); // R14
            end else if (wait_cnt != '0) begin
               wait_cnt <= wait_cnt - WAIT_W'(1);
            end
            rdy <= (wait_cnt == '0) && !lnk.sar_wake;
         end
      end

      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            run <= 1'b0;
         end else if (ce_i) begin
            if (lnk.sar_single[g]) begin
               run <= 1'b0; // R17
            end else if (lnk.sar_start[g] || lnk.sar_sof[g]) begin
               run <= 1'b1; // R17 R18
            end
         end
      end

      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            eoc <= 1'b0;
            res <= '0;
         end else if (ce_i) begin
            if (done) begin
               eoc <= 1'b1; // R15 R16 R18
               res <= eng_res; // R09
            end else if (lnk.sar_rd[g]) begin
               eoc <= 1'b0; // R15
            end
         end
      end

      assign lnk.sar_eoc[g]    = eoc;
      assign lnk.sar_ready[g]  = rdy;
      assign lnk.sar_result[g] = res;

      adcsq_sar u_sar (
         .mclk_i   (mclk_i),
         .nrst_i   (nrst_i),
         .ce_i     (ce_i),
         .tick_i   (lnk.sar_tick),
         .go_i     (go),
         .cmp_i    (sar_cmp_i[g]),
         .dac_o    (sar_dac_o[g]),
         .result_o (eng_res),
         .done_o   (done),
         .busy_o   (busy)
      );
   end
endmodule
`default_nettype wire

// file: src/adcsq_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctl (
   input  wire logic                         mclk_i,
   input  wire logic                         nrst_i,
   input  wire logic                         ce_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [7:0]                   wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic [31:0]                       wb_dat_o,
   output logic                              wb_ack_o,
   input  wire logic                         ds_soc_i,
   input  wire logic [adcsq_pkg::SAR_N-1:0]  sar_sof_i,
   adcsq_if.ctl                              lnk
);
   import adcsq_pkg::*;

   logic              acc;
   logic              wr0;
   logic              wr1;
   logic              rd;
   logic [7:0]        sar_off;
   logic              sar_hit;
   logic [31:0]       rdata;
   logic [SAR_N-1:0]  pend;
   logic [2:0]        div_cnt;

   assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   assign wr0     = acc && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[0];
   assign wr1     = acc && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[1];
   assign rd      = acc && !wb_we_i;
   assign sar_off = wb_adr_i - ADR_SAR;
   assign sar_hit = (wb_adr_i >= ADR_SAR) && (sar_off[1:0] == 2'b00) && (sar_off[7:2] < 6'(SAR_N));

   always_comb begin
      rdata = '0;
      case (wb_adr_i)
         ADR_CTRL: begin
            rdata[CB_MODE +: 2]        = lnk.ds_mode;
            rdata[CB_RES +: RES_W]     = lnk.ds_res;
            rdata[CB_SINGLE +: SAR_N]  = lnk.sar_single;
         end
         ADR_STAT: begin // R05
            rdata[SB_DS_EOC]           = lnk.ds_eoc;
            rdata[SB_DS_VALID]         = lnk.ds_valid;
            rdata[SB_DS_BUSY]          = lnk.ds_busy;
            rdata[SB_SAR_EOC +: SAR_N] = lnk.sar_eoc;
            rdata[SB_SAR_RDY +: SAR_N] = lnk.sar_ready;
         end
         ADR_DS_RES: rdata[DS_W-1:0] = lnk.ds_result;
         default: begin
            if (sar_hit) begin
               rdata[SAR_W-1:0] = lnk.sar_result[sar_off[2 +: $clog2(SAR_N)]];
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce_i) begin
         wb_ack_o <= acc;
         if (rd) begin
            wb_dat_o <= rdata;
         end
      end
   end

   // Command pulses and configuration toward the converters
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lnk.ds_start    <= 1'b0;
         lnk.ds_stop     <= 1'b0;
         lnk.ds_mux      <= 1'b0;
         lnk.ds_rd       <= 1'b0;
         lnk.ds_hw_start <= 1'b0;
         lnk.ds_mode     <= ADCSQ_SINGLE;
         lnk.ds_res      <= RES_W'(RES_DEF);
         lnk.sar_wake    <= 1'b0;
         lnk.sar_single  <= '1;
         lnk.sar_rd      <= '0;
         lnk.sar_sof     <= '0;
      end else if (ce_i) begin
         lnk.ds_start    <= wr0 && wb_dat_i[CB_DS_START];
         lnk.ds_stop     <= wr0 && wb_dat_i[CB_DS_STOP];
         // R02
         lnk.ds_mux      <= wr0 && wb_dat_i[CB_MUX] && !(lnk.ds_mode == ADCSQ_CONT && lnk.ds_busy);
         lnk.sar_wake    <= wr0 && wb_dat_i[CB_WAKE];
         lnk.ds_hw_start <= ds_soc_i; // R08
         lnk.ds_rd       <= rd && (wb_adr_i == ADR_DS_RES); // R05
         lnk.sar_sof     <= sar_sof_i & lnk.sar_ready; // R13 R14
         if (wr0) begin
            lnk.ds_mode <= adcsq_mode_t'(wb_dat_i[CB_MODE +: 2]);
         end
         if (wr1) begin
            lnk.ds_res     <= wb_dat_i[CB_RES +: RES_W];
            lnk.sar_single <= wb_dat_i[CB_SINGLE +: SAR_N];
         end
         for (int i = 0; i < SAR_N; i++) begin
            lnk.sar_rd[i] <= rd && sar_hit && (sar_off[7:2] == 6'(i));
         end
      end
   end

   // Software SAR starts held until the converter is ready
   for (genvar g = 0; g < SAR_N; g++) begin : g_go
      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            pend[g]          <= 1'b0;
            lnk.sar_start[g] <= 1'b0;
         end else if (ce_i) begin
            lnk.sar_start[g] <= pend[g] && lnk.sar_ready[g] && !lnk.sar_start[g]; // R14
            if (wr0 && wb_dat_i[CB_SAR_GO + g]) begin
               pend[g] <= 1'b1;
            end else if (lnk.sar_start[g]) begin
               pend[g] <= 1'b0;
            end
         end
      end
   end

   // Converter clock enable at no more than 16 MHz
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt      <= '0;
         lnk.sar_tick <= 1'b0;
      end else if (ce_i) begin
         lnk.sar_tick <= (div_cnt == 3'(SAR_DIV - 1)); // R11
         if (div_cnt == 3'(SAR_DIV - 1)) begin
            div_cnt <= '0;
         end else begin
            div_cnt <= div_cnt + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/adcsq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_assertions
   import adcsq_pkg::*;
(
   input wire logic             mclk_i,
   input wire logic             nrst_i,
   input wire logic             ds_start,
   input wire logic             ds_stop,
   input wire logic             ds_hw_start,
   input wire logic             ds_mux,
   input wire logic             ds_rd,
   input wire adcsq_mode_t      ds_mode,
   input wire logic             ds_eoc,
   input wire logic             ds_valid,
   input wire logic             ds_busy,
   input wire logic             sar_tick,
   input wire logic             sar_wake,
   input wire logic [SAR_N-1:0] sar_start,
   input wire logic [SAR_N-1:0] sar_rd,
   input wire logic [SAR_N-1:0] sar_eoc,
   input wire logic [SAR_N-1:0] sar_ready
);
   logic [9:0] wait_cnt;
   // Cycles since reset or wake
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         wait_cnt <= 10'h000;
      else if (sar_wake)
         wait_cnt <= 10'h000;
      else if (wait_cnt != 10'h3FF)
         wait_cnt <= wait_cnt + 10'h001;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   chk_ds_hold: assert property (ds_eoc && !ds_rd |=> ds_eoc)
      else $error("ds done dropped unread");
   chk_sar_hold: assert property (sar_eoc[0] && !sar_rd[0] |=> sar_eoc[0])
      else $error("sar done dropped unread");
   chk_ds_prime: assert property (ds_start && !ds_busy && !ds_eoc |=> !ds_eoc [*8])
      else $error("ds result before priming");
   chk_ds_go: assert property ((ds_start || ds_hw_start) && !ds_busy && !ds_stop |-> ##[1:2] ds_busy)
      else $error("ds start not taken");
   chk_sar_done: assert property (sar_start[0] && sar_ready[0] && !sar_eoc[0] |-> ##[60:80] sar_eoc[0])
      else $error("sar conversion time wrong");
   chk_tick_gap: assert property (sar_tick |=> !sar_tick [*3] ##1 sar_tick)
      else $error("sar tick spacing wrong");
   chk_sar_wait: assert property (sar_ready[0] && !$past(sar_wake) && !$past(sar_wake, 2)
      |-> wait_cnt >= 10'h1EF)
      else $error("sar ready too early");
   chk_mux_inval: assert property (ds_mux && ds_mode != ADCSQ_CONT |-> ##2 !ds_valid)
      else $error("valid after mux switch");
   cover property ($rose(ds_eoc) && ds_mode == ADCSQ_TURBO);
   cover property ($rose(sar_eoc[1]));
   cover property ($rose(ds_valid));
endmodule
`default_nettype wire

// file: tb/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
   import adcsq_pkg::*;
   localparam int P = 16;
   typedef struct {logic [31:0] v; logic [31:0] m;} adcsq_note_t;
   logic                        mclk_i = 1'b0;
   logic                        nrst_i = 1'b0;
   logic                        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ds_soc = 1'b0;
   logic [7:0]                  adr = 8'h00;
   logic [3:0]                  sel = 4'h0;
   logic [31:0]                 wdat = 32'h0, rdat;
   logic [1:0]                  sof = 2'h0, cmp = 2'h0;
   logic [DS_W-1:0]             mod = '0;
   logic [SAR_N-1:0][SAR_W-1:0] dac;
   logic [SAR_W-1:0]            ana [SAR_N] = '{default: '0};
   int                          err_total = 0, n_checks = 0, cyc_n = 0, t0;
   adcsq_note_t                 q[$];
   adcsq_if lnk ();
   adcsq_dev #(.DS_PERIOD(P)) u_adcsq_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .lnk(lnk),
      .ds_mod_i(mod), .sar_cmp_i(cmp), .sar_dac_o(dac));
   adcsq_ctl u_adcsq_ctl (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ds_soc_i(ds_soc), .sar_sof_i(sof), .lnk(lnk));
   adcsq_assertions u_adcsq_assertions (.mclk_i(mclk_i), .nrst_i(nrst_i), .ds_start(lnk.ds_start),
      .ds_stop(lnk.ds_stop), .ds_hw_start(lnk.ds_hw_start), .ds_mux(lnk.ds_mux), .ds_rd(lnk.ds_rd),
      .ds_mode(lnk.ds_mode), .ds_eoc(lnk.ds_eoc), .ds_valid(lnk.ds_valid), .ds_busy(lnk.ds_busy),
      .sar_tick(lnk.sar_tick), .sar_wake(lnk.sar_wake), .sar_start(lnk.sar_start), .sar_rd(lnk.sar_rd),
      .sar_eoc(lnk.sar_eoc), .sar_ready(lnk.sar_ready));
   initial forever #10 mclk_i = ~mclk_i;
   // Comparator model of the analog inputs
   always @(posedge mclk_i) begin
      cyc_n <= cyc_n + 1;
      for (int c = 0; c < SAR_N; c++)
         cmp[c] <= (ana[c] >= dac[c]);
   end
   // Read monitor takes the oldest note
   always @(posedge mclk_i) begin
      adcsq_note_t n;
      if (ack && !we && q.size() > 0) begin
         n = q.pop_front();
         if (n.m != 32'h0)
            chk("wb read", n.v & n.m, rdat & n.m);
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic fail_out(input string nm);
      chk(nm, 32'h0, 32'h1);
      report_and_stop();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge mclk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k == 50)
         fail_out("ack timeout");
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      q.push_back('{e, m});
      bus(1'b0, a, 32'h0);
   endtask
   function automatic logic hit(input int w);
      return w == 0 ? lnk.ds_eoc : (w == 1 ? &lnk.sar_eoc : &lnk.sar_ready);
   endfunction
   task automatic wait_for(input int w);
      int k;
      k = 0;
      while (hit(w) !== 1'b1 && k < 2000) begin
         @(posedge mclk_i);
         k++;
      end
      if (k == 2000)
         fail_out("wait timeout");
   endtask
   initial begin
      int v, v2, gap;
      logic [1:0] md;
      logic [4:0] res;
      logic ct;
      void'($urandom(32'hC593));
      repeat (5) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rd(ADR_STAT, 32'h0, 32'h7F);
      rd(8'h20, 32'h0, 32'hFFFFFFFF);
      for (int i = 0; i < 3; i++) begin
         wait_for(2);
         for (int c = 0; c < SAR_N; c++)
            ana[c] = SAR_W'($urandom);
         if (i == 1) begin
            sof <= 2'b11;
            @(posedge mclk_i);
            sof <= 2'b00;
         end else
            bus(1'b1, ADR_CTRL, i == 2 ? 32'h0060 : 32'h7060);
         wait_for(1);
         rd(ADR_SAR, 32'(ana[0]), 32'hFFF);
         rd(ADR_SAR + 8'h04, 32'(ana[1]), 32'hFFF);
         rd(ADR_STAT, 32'h0, 32'h18);
         if (i == 2) begin
            wait_for(1);
            rd(ADR_SAR, 32'(ana[0]), 32'hFFF);
         end
      end
      bus(1'b1, ADR_CTRL, 32'h7080);
      repeat (3) @(posedge mclk_i);
      rd(ADR_STAT, 32'h0, 32'h60);
      for (int m = 0; m < 5; m++) begin
         md = (m == 4) ? 2'd3 : 2'(m);
         res = (m == 4) ? 5'h11 : 5'h10;
         ct = (m == 2 || m == 4);
         v = int'($urandom & 32'h3FFFF);
         v2 = int'($urandom & 32'h3FFFF);
         mod <= DS_W'(v);
         if (m == 1) begin
            bus(1'b1, ADR_CTRL, {17'h0, 2'b11, res, 3'b000, 1'b1, md, 2'b00});
            rd(ADR_STAT, 32'h0, 32'h2);
            t0 = cyc_n;
            ds_soc <= 1'b1;
            @(posedge mclk_i);
            ds_soc <= 1'b0;
         end else begin
            t0 = cyc_n;
            bus(1'b1, ADR_CTRL, {17'h0, 2'b11, res, 3'b000, 1'b0, md, 2'b01});
         end
         wait_for(0);
         gap = cyc_n - t0;
         chk("first delay", 32'h1, 32'(gap >= 4 * P && gap <= 4 * P + 8));
         mod <= DS_W'(v2);
         t0 = cyc_n;
         rd(ADR_DS_RES, 32'(v), 32'hFFFFF);
         @(posedge mclk_i);
         if (m == 0) begin
            repeat (5 * P) @(posedge mclk_i);
            rd(ADR_STAT, 32'h0, 32'h5);
         end else begin
            wait_for(0);
            gap = cyc_n - t0;
            chk("next gap", 32'h1, 32'(ct ? gap <= P + 2 : gap >= 3 * P));
            rd(ADR_DS_RES, 32'(ct ? (3 * v + v2) >> 2 : v2), 32'hFFFFF);
            rd(ADR_STAT, 32'h2, 32'h2);
            bus(1'b1, ADR_CTRL, 32'h6002);
         end
      end
      @(posedge mclk_i);
      chk("notes left", 32'h0, 32'(q.size()));
      report_and_stop();
   end
endmodule
`default_nettype wire
